// ==== design/ide_register_bus_port.sv ====
// Function
// RULE_01: the device is in its native disk mode from power-up, so the host starts driving at once.
// RULE_02: after power-up data register transfers are full 16-bit words on both lanes.
// RULE_03: byte-wide data transfers are used only after a set-features command enabled them.
// RULE_04: reads of data use both lanes, reads via the second select at 6h use the low lane only.
// RULE_05: writes of data drive both lanes, control writes via the second select drive the low lane.
// RULE_06: task-file addresses 1 to 7 carry a byte on the low lane, the high lane left undriven.
// RULE_07: each register access cycle lasts at least the mode's minimum, 600 ns down to 120 ns.
// RULE_08: each pio data cycle lasts at least 600, 383, 240, 180 or 120 ns for modes 0 to 4.
// RULE_09: byte register strobes last at least 290 ns in modes 0 to 2, 80 ns and 70 ns above.
// RULE_10: 16-bit data strobes last at least 165, 125, 100, 80 or 70 ns for modes 0 to 4.
// RULE_11: the three address lines pick one of eight task-file registers.
// RULE_12: the first select enables the task file, the second only alt status and control.
`timescale 1ns/1ps
module ide_register_bus_port
  import ide_host_pkg::*;
#(
  parameter logic [7:0] CMD_SET_FEATURES = 8'hEF,
  parameter logic [7:0] FEAT_ENABLE_8BIT = 8'h01,
  parameter logic [7:0] FEAT_DISABLE_8BIT = 8'h81
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] pioMode,
  input wire logic reqValid,
  output logic reqReady,
  input wire ide_host_pkg::hostReq_t req,
  output logic respValid,
  input wire logic respReady,
  output logic [15:0] respData,
  output logic byteMode,
  output logic busy,
  output ide_host_pkg::idePins_t pins,
  input wire logic [15:0] dataIn
);
  import ide_host_pkg::*;

  phase_t state_r, state_nxt;
  hostReq_t cur_r, cur_nxt;
  idePins_t pins_r, pins_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic [7:0] phaseCnt_r, phaseCnt_nxt;
  logic [7:0] totalCnt_r, totalCnt_nxt;
  logic [7:0] feature_r, feature_nxt;
  logic byteMode_r, byteMode_nxt;
  logic reqReady_r, reqReady_nxt;
  logic busy_r, busy_nxt;
  logic [15:0] sync1_r, sync2_r;
  logic [7:0] setupCyc, strobeCyc, holdCyc, recovCyc, cycleCyc;
  logic dataWide;
  logic pushValid;
  logic pushReady;
  logic [15:0] pushData;

  // ----------------------------------------------------------------
  // read data synchroniser
  // ----------------------------------------------------------------
  // data pins come from outside the clock domain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_r <= DATA_RST;
      sync2_r <= DATA_RST;
    end else begin
      sync1_r <= dataIn;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // per-access timing from the current mode
  // ----------------------------------------------------------------
  // wide data register accesses take the pio figures
  assign dataWide = !cur_r.ctrlSel && (cur_r.addr == ADDR_DATA) && cur_r.wide;

  always_comb begin
    holdCyc = ns2cyc(WR_HOLD_NS[mode_r]);
    if (ns2cyc(ADDR_HOLD_NS[mode_r]) > holdCyc) begin
      holdCyc = ns2cyc(ADDR_HOLD_NS[mode_r]);
    end
    setupCyc = ns2cyc(SETUP_NS[mode_r]);
    recovCyc = ns2cyc(RECOVERY_NS[mode_r]);
    if (dataWide) begin
      strobeCyc = ns2cyc(PIO_STROBE_NS[mode_r]); // RULE_10
      cycleCyc = ns2cyc(PIO_CYCLE_NS[mode_r]); // RULE_08
    end else begin
      strobeCyc = ns2cyc(REG_STROBE_NS[mode_r]); // RULE_09
      cycleCyc = ns2cyc(REG_CYCLE_NS[mode_r]); // RULE_07
    end
    // reads stretch strobe and cycle by the synchroniser delay
    if (!cur_r.write) begin
      strobeCyc = strobeCyc + 8'(SYNC_STAGES);
      cycleCyc = cycleCyc + 8'(SYNC_STAGES);
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // next state, counters, mode flag and pin values
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    mode_nxt = mode_r;
    phaseCnt_nxt = phaseCnt_r;
    totalCnt_nxt = totalCnt_r;
    feature_nxt = feature_r;
    byteMode_nxt = byteMode_r;
    pushValid = 1'b0;
    pushData = 16'h0000;
    pins_nxt = PINS_IDLE;
    case (state_r)
      ST_IDLE: begin
        if (reqValid && reqReady_r) begin
          cur_nxt = req;
          // data register stays word wide until byte mode is on
          if (!req.ctrlSel && req.addr == ADDR_DATA && !byteMode_r) begin
            cur_nxt.wide = 1'b1; // RULE_02 RULE_03
          end
          if (req.ctrlSel || req.addr != ADDR_DATA) begin
            cur_nxt.wide = 1'b0; // RULE_06
          end
          mode_nxt = (pioMode > MAX_MODE) ? MAX_MODE : pioMode;
          phaseCnt_nxt = CNT_RST;
          totalCnt_nxt = CNT_RST;
          state_nxt = ST_SETUP; // RULE_01
        end
      end
      ST_SETUP: begin
        phaseCnt_nxt = phaseCnt_r + 8'h01;
        totalCnt_nxt = totalCnt_r + 8'h01;
        if (phaseCnt_nxt >= setupCyc) begin
          phaseCnt_nxt = CNT_RST;
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        phaseCnt_nxt = phaseCnt_r + 8'h01;
        totalCnt_nxt = totalCnt_r + 8'h01;
        if (phaseCnt_nxt >= strobeCyc) begin
          phaseCnt_nxt = CNT_RST;
          state_nxt = ST_HOLD;
          if (!cur_r.write) begin
            pushValid = 1'b1;
            pushData = {cur_r.wide ? sync2_r[15:8] : 8'h00, sync2_r[7:0]}; // RULE_04
          end else if (!cur_r.ctrlSel && cur_r.addr == ADDR_FEATURE) begin
            feature_nxt = cur_r.data[7:0];
          end else if (!cur_r.ctrlSel && cur_r.addr == ADDR_COMMAND &&
                       cur_r.data[7:0] == CMD_SET_FEATURES) begin
            // track the device's byte transfer mode
            if (feature_r == FEAT_ENABLE_8BIT) begin
              byteMode_nxt = 1'b1; // RULE_03
            end else if (feature_r == FEAT_DISABLE_8BIT) begin
              byteMode_nxt = 1'b0; // RULE_03
            end
          end
        end
      end
      ST_HOLD: begin
        phaseCnt_nxt = phaseCnt_r + 8'h01;
        totalCnt_nxt = totalCnt_r + 8'h01;
        if (phaseCnt_nxt >= holdCyc) begin
          phaseCnt_nxt = CNT_RST;
          state_nxt = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        phaseCnt_nxt = phaseCnt_r + 8'h01;
        totalCnt_nxt = totalCnt_r + 8'h01;
        // full cycle time and strobe recovery both met
        if (totalCnt_nxt >= cycleCyc && phaseCnt_nxt >= recovCyc) begin // RULE_07 RULE_08
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // pins follow the next phase; recovery drops the selects
    if (state_nxt != ST_IDLE && state_nxt != ST_RECOVER) begin
      pins_nxt.cs1N = cur_nxt.ctrlSel; // RULE_12
      pins_nxt.cs2N = !cur_nxt.ctrlSel; // RULE_12
      pins_nxt.addr = cur_nxt.addr; // RULE_11
      pins_nxt.iordN = !(state_nxt == ST_STROBE && !cur_nxt.write);
      pins_nxt.iowrN = !(state_nxt == ST_STROBE && cur_nxt.write);
      if (cur_nxt.write) begin
        pins_nxt.dataOut = cur_nxt.wide ? cur_nxt.data : {8'h00, cur_nxt.data[7:0]};
        pins_nxt.dataOeLoN = 1'b0; // RULE_05
        pins_nxt.dataOeHiN = !cur_nxt.wide; // RULE_05 RULE_06
      end
    end
  end

  // new requests only while idle and read space is free
  assign reqReady_nxt = (state_nxt == ST_IDLE) && pushReady;
  assign busy_nxt = (state_nxt != ST_IDLE);

  // sequencer registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      pins_r <= PINS_IDLE;
      mode_r <= 3'h0;
      phaseCnt_r <= CNT_RST;
      totalCnt_r <= CNT_RST;
      feature_r <= 8'h00;
      byteMode_r <= 1'b0; // RULE_02
      reqReady_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      pins_r <= pins_nxt;
      mode_r <= mode_nxt;
      phaseCnt_r <= phaseCnt_nxt;
      totalCnt_r <= totalCnt_nxt;
      feature_r <= feature_nxt;
      byteMode_r <= byteMode_nxt;
      reqReady_r <= reqReady_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data buffer and outputs
  // ----------------------------------------------------------------
  two_entry_buffer #(
    .WIDTH(16)
  ) u_rdbuf (
    .clock(clock),
    .sys_rst(sys_rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(respValid),
    .outReady(respReady),
    .outData(respData)
  );

  assign pins = pins_r;
  assign reqReady = reqReady_r;
  assign byteMode = byteMode_r;
  assign busy = busy_r;

endmodule : ide_register_bus_port

// ==== design/ide_host_pkg.sv ====
package ide_host_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_STAGES = 2;
  localparam int NUM_MODES = 5;
  localparam logic [2:0] MAX_MODE = 3'h4;

  // register (8-bit) access timing per mode 0..4, ns
  localparam int REG_CYCLE_NS [0:4] = '{600, 383, 330, 180, 120};
  localparam int REG_STROBE_NS [0:4] = '{290, 290, 290, 80, 70};
  // pio (16-bit data) access timing per mode 0..4, ns
  localparam int PIO_CYCLE_NS [0:4] = '{600, 383, 240, 180, 120};
  localparam int PIO_STROBE_NS [0:4] = '{165, 125, 100, 80, 70};
  // shared figures per mode 0..4, ns
  localparam int SETUP_NS [0:4] = '{70, 50, 30, 30, 25};
  localparam int WR_HOLD_NS [0:4] = '{30, 20, 15, 10, 10};
  localparam int ADDR_HOLD_NS [0:4] = '{20, 15, 10, 10, 10};
  localparam int RECOVERY_NS [0:4] = '{0, 0, 0, 70, 25};

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_FEATURE = 3'h1;
  localparam logic [2:0] ADDR_COMMAND = 3'h7;
  localparam logic [2:0] ADDR_ALT_STATUS = 3'h6;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_RECOVER = 3'h6
  } phase_t;

  typedef struct packed {
    logic write;
    logic ctrlSel;
    logic [2:0] addr;
    logic wide;
    logic [15:0] data;
  } hostReq_t;

  typedef struct packed {
    logic cs1N;
    logic cs2N;
    logic [2:0] addr;
    logic iordN;
    logic iowrN;
    logic [15:0] dataOut;
    logic dataOeLoN;
    logic dataOeHiN;
  } idePins_t;

  localparam idePins_t PINS_IDLE = '{cs1N: 1'b1, cs2N: 1'b1, addr: 3'h0, iordN: 1'b1,
                                     iowrN: 1'b1, dataOut: 16'h0000, dataOeLoN: 1'b1,
                                     dataOeHiN: 1'b1};

  // least time in ns to whole cycles, never below one
  function automatic logic [7:0] ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction : ns2cyc

endpackage : ide_host_pkg

// ==== design/two_entry_buffer.sv ====
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  logic outValid_r, outValid_nxt;
  logic spareValid_r, spareValid_nxt;
  logic [WIDTH-1:0] out_r, out_nxt;
  logic [WIDTH-1:0] spare_r, spare_nxt;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // head slot plus spare slot
  // ----------------------------------------------------------------
  assign inReady = !spareValid_r;
  assign outValid = outValid_r;
  assign outData = out_r;
  assign push = inValid && !spareValid_r;
  assign pop = outValid_r && outReady;

  // next contents of the two slots
  always_comb begin
    outValid_nxt = outValid_r;
    spareValid_nxt = spareValid_r;
    out_nxt = out_r;
    spare_nxt = spare_r;
    if (!outValid_r || pop) begin
      if (spareValid_r) begin
        out_nxt = spare_r;
        outValid_nxt = 1'b1;
        spareValid_nxt = push;
        if (push) begin
          spare_nxt = inData;
        end
      end else begin
        outValid_nxt = push;
        if (push) begin
          out_nxt = inData;
        end
      end
    end else if (push) begin
      spare_nxt = inData;
      spareValid_nxt = 1'b1;
    end
  end

  // slot registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outValid_r <= 1'b0;
      spareValid_r <= 1'b0;
      out_r <= '0;
      spare_r <= '0;
    end else begin
      outValid_r <= outValid_nxt;
      spareValid_r <= spareValid_nxt;
      out_r <= out_nxt;
      spare_r <= spare_nxt;
    end
  end

endmodule : two_entry_buffer

// ==== dv/ide_register_bus_port_assertions.sv ====
`timescale 1ns/1ps
module ide_register_bus_port_assertions
  import ide_host_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] pioMode,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire ide_host_pkg::hostReq_t req,
  input wire logic byteMode,
  input wire ide_host_pkg::idePins_t pins
);
  import ide_host_pkg::*;
  // --------
  // strobe bookkeeping
  // --------
  logic strobe, prev_r, wide_r, wide_nxt, gWide_r;
  logic [2:0] mode_r, mode_nxt, gMode_r;
  logic [7:0] low_r, low_nxt, gap_r, gap_nxt, needW, needC;
  assign strobe = !(pins.iordN && pins.iowrN);
  // latch mode and width class at take, count low time and spacing
  always_comb begin
    mode_nxt = mode_r;
    wide_nxt = wide_r;
    if (reqValid && reqReady) begin
      mode_nxt = (pioMode > 3'h4) ? 3'h4 : pioMode;
      wide_nxt = !req.ctrlSel && req.addr == 3'h0 && (req.wide || !byteMode);
    end
    low_nxt = strobe ? low_r + 8'h01 : 8'h00;
    gap_nxt = (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
    if (strobe && !prev_r) gap_nxt = 8'h01;
    // whole cycles, rounded up, narrowed only after the divide
    needW = 8'(((wide_r ? PIO_STROBE_NS[mode_r] : REG_STROBE_NS[mode_r]) + 24) / 25);
    needC = 8'(((gWide_r ? PIO_CYCLE_NS[gMode_r] : REG_CYCLE_NS[gMode_r]) + 24) / 25);
    if (8'(((wide_r ? PIO_CYCLE_NS[mode_r] : REG_CYCLE_NS[mode_r]) + 24) / 25) < needC) begin
      needC = 8'(((wide_r ? PIO_CYCLE_NS[mode_r] : REG_CYCLE_NS[mode_r]) + 24) / 25);
    end
  end
  // registers only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {prev_r, wide_r, gWide_r, mode_r, gMode_r, low_r, gap_r} <= {3'h0, 6'h00, 8'h00, 8'hFF};
    end else begin
      prev_r <= strobe;
      mode_r <= mode_nxt;
      wide_r <= wide_nxt;
      low_r <= low_nxt;
      gap_r <= gap_nxt;
      if (strobe && !prev_r) {gMode_r, gWide_r} <= {mode_r, wide_r};
    end
  end
  // --------
  // properties
  // --------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence strobeHeld;
    strobe && prev_r;
  endsequence
  a_select_excl: assert property (!(!pins.cs1N && !pins.cs2N))
    else $error("both selects low");
  a_ctrl_addr: assert property (!pins.cs2N |-> pins.addr == ADDR_ALT_STATUS)
    else $error("second select off 6h");
  a_high_lane: assert property ((!pins.cs2N || pins.addr != 3'h0) && !pins.iowrN |-> pins.dataOeHiN)
    else $error("high lane driven on byte write");
  a_word_mode: assert property (!byteMode && !pins.cs1N && pins.addr == 3'h0 && !pins.iowrN
    |-> !pins.dataOeHiN && !pins.dataOeLoN)
    else $error("data write not full word");
  a_read_release: assert property (!pins.iordN |-> pins.dataOeLoN && pins.dataOeHiN)
    else $error("host drives bus during read");
  a_one_strobe: assert property (!(!pins.iordN && !pins.iowrN))
    else $error("both strobes low");
  a_addr_steady: assert property (strobeHeld |-> $stable(pins.addr) && $stable(pins.cs1N)
    && $stable(pins.cs2N))
    else $error("address moved under strobe");
  a_strobe_width: assert property (prev_r && !strobe |-> low_r >= needW)
    else $error("strobe too short");
  a_cycle_time: assert property (strobe && !prev_r |-> gap_r >= needC)
    else $error("access cycle too short");
endmodule : ide_register_bus_port_assertions

bind ide_register_bus_port ide_register_bus_port_assertions chk_i (.clock(clock),
  .sys_rst(sys_rst), .pioMode(pioMode), .reqValid(reqValid), .reqReady(reqReady), .req(req),
  .byteMode(byteMode), .pins(pins));

// ==== dv/disk_device_model.sv ====
`timescale 1ns/1ps
module disk_device_model
  import ide_host_pkg::*;
#(
  parameter logic [7:0] STATUS_VAL = 8'h50
) (
  input wire ide_host_pkg::idePins_t pins,
  output logic [15:0] dataIn
);
  import ide_host_pkg::*;
  logic [15:0] word, drv;
  logic [7:0] taskReg [1:7];
  logic [7:0] ctrlReg;
  logic byteEn, flip, hiOn, loOn;
  // word mode and plain disk mode from power-up
  initial begin
    word = 16'h0000;
    ctrlReg = 8'h00;
    byteEn = 1'b0;
    flip = 1'b0;
    for (int i = 1; i < 8; i++) taskReg[i] = 8'h00;
  end
  // undriven lanes keep changing
  always #7 flip = ~flip;
  // read decode by select and address
  always_comb begin
    {hiOn, loOn, drv} = 18'h00000;
    if (!pins.iordN && pins.cs1N != pins.cs2N) begin
      if (!pins.cs1N && pins.addr == 3'h0) {hiOn, loOn, drv} = {2'h3, word};
      else if (!pins.cs1N) {loOn, drv[7:0]} = {1'b1, taskReg[pins.addr]};
      else if (pins.addr == 3'h6) {loOn, drv[7:0]} = {1'b1, STATUS_VAL};
    end
    dataIn[15:8] = !pins.dataOeHiN ? pins.dataOut[15:8] : hiOn ? drv[15:8] : {8{flip}} ^ 8'hA5;
    dataIn[7:0] = !pins.dataOeLoN ? pins.dataOut[7:0] : loOn ? drv[7:0] : {8{flip}} ^ 8'h5A;
  end
  // writes land at strobe end, from bus levels
  always @(posedge pins.iowrN) begin
    if (!pins.cs1N && pins.cs2N && pins.addr == 3'h0) begin
      word = byteEn ? {word[15:8], dataIn[7:0]} : dataIn;
    end else if (!pins.cs1N && pins.cs2N) begin
      taskReg[pins.addr] = dataIn[7:0];
      if (pins.addr == 3'h7 && dataIn[7:0] == 8'hEF && taskReg[1] == 8'h01) byteEn = 1'b1;
      if (pins.addr == 3'h7 && dataIn[7:0] == 8'hEF && taskReg[1] == 8'h81) byteEn = 1'b0;
    end else if (!pins.cs2N && pins.cs1N && pins.addr == 3'h6) begin
      ctrlReg = dataIn[7:0];
    end
  end
endmodule : disk_device_model

// ==== dv/ide_register_bus_port_tb.sv ====
`timescale 1ns/1ps
module ide_register_bus_port_tb;
  import ide_host_pkg::*;
  localparam logic [7:0] STAT = 8'h50;
  logic clock, sys_rst, reqValid, reqReady, respValid, respReady, byteMode, busy;
  logic [2:0] pioMode;
  logic [15:0] respData, dataIn, w, rd;
  hostReq_t req;
  idePins_t pins;
  int n_fail, total_checks, k;
  logic [31:0] seed;
  ide_register_bus_port ide_register_bus_port_i (.clock(clock), .sys_rst(sys_rst),
    .pioMode(pioMode), .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .respValid(respValid), .respReady(respReady), .respData(respData), .byteMode(byteMode),
    .busy(busy), .pins(pins), .dataIn(dataIn));
  disk_device_model #(.STATUS_VAL(STAT)) disk_device_model_i (.pins(pins), .dataIn(dataIn));
  // clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // --------
  // helpers
  // --------
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang();
    n_fail++;
    $display("CHECK FAILED wait expected done seen timeout");
    finish_test();
  endtask : hang
  task automatic access(input logic wr, cs, input logic [2:0] a, input logic wd,
                        input logic [15:0] d, input logic [2:0] m);
    req = '{write: wr, ctrlSel: cs, addr: a, wide: wd, data: d};
    pioMode = m;
    reqValid = 1'b1;
    k = 0;
    while (!reqReady && k < 400) begin
      @(posedge clock); #2; k++;
    end
    if (k == 400) hang();
    @(posedge clock); #2;
    reqValid = 1'b0;
    // let one edge pass before the next request
    @(posedge clock); #2;
  endtask : access
  task automatic readBack(input logic cs, input logic [2:0] a, input logic wd,
                          input logic [2:0] m);
    access(1'b0, cs, a, wd, 16'h0000, m);
    k = 0;
    while (!respValid && k < 400) begin
      @(posedge clock); #2; k++;
    end
    if (k == 400) hang();
    rd = respData;
  endtask : readBack
  task automatic idle();
    k = 0;
    while ((busy || !reqReady) && k < 400) begin
      @(posedge clock); #2; k++;
    end
    if (k == 400) hang();
  endtask : idle
  // --------
  // main sequence
  // --------
  initial begin
    {sys_rst, respReady, reqValid, pioMode, req, n_fail, total_checks} = '0;
    sys_rst = 1'b1;
    respReady = 1'b1;
    seed = 32'h0000F35A;
    repeat (12) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    chk("reset state", 16'h000F, {10'h000, byteMode, busy, pins.cs1N, pins.cs2N,
        pins.dataOeHiN, pins.dataOeLoN});
    $display("test reset done");
    for (int m = 0; m < 5; m++) begin
      w = rnd();
      access(1'b1, 1'b0, 3'h0, m[0], w, 3'(m));
      readBack(1'b0, 3'h0, 1'b1, 3'(m));
      chk("data word", w, rd);
    end
    $display("test word data done");
    for (int a = 1; a < 7; a++) begin
      w = rnd();
      access(1'b1, 1'b0, 3'(a), 1'b1, w, 3'(w % 5));
      readBack(1'b0, 3'(a), 1'b1, 3'(w % 5));
      chk("task byte", {8'h00, w[7:0]}, rd);
    end
    $display("test task file done");
    access(1'b1, 1'b1, 3'h6, 1'b0, 16'h0002, 3'h3);
    readBack(1'b1, 3'h6, 1'b0, 3'h3);
    chk("alt status", {8'h00, STAT}, rd);
    chk("control write", 16'h0002, {8'h00, disk_device_model_i.ctrlReg});
    $display("test control done");
    access(1'b1, 1'b0, 3'h1, 1'b0, 16'h0001, 3'h4);
    access(1'b1, 1'b0, 3'h7, 1'b0, 16'h00EF, 3'h4);
    idle();
    chk("byte mode on", 16'h0001, {15'h0000, byteMode});
    w = rnd();
    access(1'b1, 1'b0, 3'h0, 1'b0, w, 3'h2);
    readBack(1'b0, 3'h0, 1'b0, 3'h2);
    chk("byte data", {8'h00, w[7:0]}, rd);
    access(1'b1, 1'b0, 3'h1, 1'b0, 16'h0081, 3'h4);
    access(1'b1, 1'b0, 3'h7, 1'b0, 16'h00EF, 3'h4);
    idle();
    chk("byte mode off", 16'h0000, {15'h0000, byteMode});
    $display("test byte mode done");
    w = rnd();
    access(1'b1, 1'b0, 3'h0, 1'b1, w, 3'h4);
    respReady = 1'b0;
    access(1'b0, 1'b0, 3'h0, 1'b1, 16'h0000, 3'h4);
    access(1'b0, 1'b0, 3'h0, 1'b1, 16'h0000, 3'h1);
    reqValid = 1'b1;
    rd = 16'h0000;
    for (int c = 0; c < 60; c++) begin
      @(posedge clock); #2;
      if (reqReady) rd = 16'h0001;
    end
    reqValid = 1'b0;
    chk("full buffer refuses", 16'h0000, rd);
    respReady = 1'b1;
    for (int n = 0; n < 2; n++) begin
      k = 0;
      while (!respValid && k < 400) begin
        @(posedge clock); #2; k++;
      end
      if (k == 400) hang();
      chk("buffered word", w, respData);
      @(posedge clock); #2;
    end
    $display("test buffer done");
    finish_test();
  end
endmodule : ide_register_bus_port_tb
